// File: hbpc_host_pins.sv
// Host bus pin front end with straps, address latch, decode and AXI4-Lite status port.
`timescale 1ns/10ps
module hbpc_host_pins #(
    parameter hbpc_pkg::hbpc_width_type EEP_WIDTH = hbpc_pkg::HBPC_WIDTH16
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        eeprom_serial_in,
    input  wire logic        eeprom_present_strap,
    input  wire logic        bus_style_strap,
    input  wire logic        sync_write_not_read,
    input  wire logic        address_qualifier_n,
    input  wire logic        write_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic        address_latch_strobe_n,
    input  wire logic        chip_powerdown_n,
    input  wire logic [15:1] host_address_lines,
    output logic             eepromDataOut,
    output logic             eepromDataValid,
    output logic             powerDown,
    output logic [1:0]       busWidth,
    output logic             asyncMode,
    output logic             hostHit,
    output logic             hostWrite,
    output logic             hostRead,
    output logic             readDriveEn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    hbpc_pin_if pin ();
    logic [23:0] syncBus;

    hbpc_pin_sync #(.W(24), .RST_VAL(hbpc_pkg::PIN_IDLE)) i_hbpc_pin_sync (
        .mclk    (mclk),
        .resetn  (resetn),
        .pinsIn  ({eeprom_serial_in, eeprom_present_strap, bus_style_strap,
                   sync_write_not_read, address_qualifier_n, write_strobe_n,
                   read_strobe_n, address_latch_strobe_n, chip_powerdown_n,
                   host_address_lines}),
        .pinsOut (syncBus)
    );

    assign pin.serialIn     = syncBus[23];
    assign pin.eepromStrap  = syncBus[22];
    assign pin.busStyle     = syncBus[21];
    assign pin.writeNotRead = syncBus[20];
    assign pin.qualN        = syncBus[19];
    assign pin.writeN       = syncBus[18];
    assign pin.readN        = syncBus[17];
    assign pin.latchStrobeN = syncBus[16];
    assign pin.powerdownN   = syncBus[15];
    assign pin.addr         = syncBus[14:0];

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // Straps are sampled once, after the synchroniser has filled, and then frozen.
    logic [1:0]  settle_reg;
    logic        strapDone_reg;
    logic        eepPresent_reg;
    logic        async_reg;
    logic [1:0]  width_reg;
    logic [1:0]  widthStrap;

    assign widthStrap = pin.busStyle ? hbpc_pkg::HBPC_WIDTH32 :
                        pin.eepromStrap ? EEP_WIDTH :
                        pin.serialIn ? hbpc_pkg::HBPC_WIDTH16 : hbpc_pkg::HBPC_WIDTH8;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            settle_reg     <= '0;
            strapDone_reg  <= 1'b0;
            eepPresent_reg <= 1'b0;
            async_reg      <= 1'b0;
            width_reg      <= hbpc_pkg::HBPC_WIDTH8;
        end else if (!strapDone_reg) begin
            settle_reg <= settle_reg + 2'h1;
            if (settle_reg == hbpc_pkg::STRAP_SETTLE) begin
                strapDone_reg  <= 1'b1;
                eepPresent_reg <= pin.eepromStrap;
                async_reg      <= pin.busStyle;
                width_reg      <= widthStrap;
            end
        end
    end

    assign busWidth  = width_reg;
    assign asyncMode = async_reg;

    // ------------------------------------------------------------------
    // Serial memory data and power-down
    // ------------------------------------------------------------------
    logic eepData_reg;
    logic powerDown_reg;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            eepData_reg   <= 1'b0;
            powerDown_reg <= 1'b0;
        end else begin
            eepData_reg   <= pin.serialIn & eepPresent_reg;
            powerDown_reg <= ~pin.powerdownN;
        end
    end

    assign eepromDataOut   = eepData_reg;
    assign eepromDataValid = strapDone_reg & eepPresent_reg;
    assign powerDown       = powerDown_reg;

    // ------------------------------------------------------------------
    // Address latch and decode
    // ------------------------------------------------------------------
    logic [15:1] latchAddr_reg;
    logic        latchQualN_reg;
    logic        adsPrevN_reg;
    logic        adsRise;
    logic [31:0] ctrl_reg;
    logic [15:1] effAddr;
    logic        effQualN;
    logic        hitNow;
    logic        hitPrev_reg;
    logic        writePrevN_reg;
    logic        readPrevN_reg;
    logic        syncStart;

    assign adsRise  = ~adsPrevN_reg & pin.latchStrobeN;
    assign effAddr  = ctrl_reg[hbpc_pkg::CTRL_LATCH_EN_BIT] ? latchAddr_reg : pin.addr;
    assign effQualN = ctrl_reg[hbpc_pkg::CTRL_LATCH_EN_BIT] ? latchQualN_reg : pin.qualN;
    assign hitNow   = ~effQualN & strapDone_reg & ~powerDown_reg
                      & (effAddr[15:4] == ctrl_reg[hbpc_pkg::CTRL_BASE_LSB +: 12]);
    assign syncStart = ~async_reg & hitNow & ~hitPrev_reg;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            latchAddr_reg  <= '0;
            latchQualN_reg <= 1'b1;
            adsPrevN_reg   <= 1'b1;
            hitPrev_reg    <= 1'b0;
            writePrevN_reg <= 1'b1;
            readPrevN_reg  <= 1'b1;
        end else begin
            adsPrevN_reg   <= pin.latchStrobeN;
            hitPrev_reg    <= hitNow;
            writePrevN_reg <= pin.writeN;
            readPrevN_reg  <= pin.readN;
            if (adsRise) begin
                latchAddr_reg  <= pin.addr;
                latchQualN_reg <= pin.qualN;
            end
        end
    end

    assign hostHit     = hitNow;
    assign hostWrite   = async_reg ? (hitNow & writePrevN_reg & ~pin.writeN)
                                   : (syncStart & pin.writeNotRead);
    assign hostRead    = async_reg ? (hitNow & readPrevN_reg & ~pin.readN)
                                   : (syncStart & ~pin.writeNotRead);
    assign readDriveEn = async_reg & hitNow & ~pin.readN;

    // ------------------------------------------------------------------
    // AXI4-Lite register port
    // ------------------------------------------------------------------
    // Both write channels are taken in the same cycle; this keeps one response in flight.
    logic [2:0]  event_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdata_reg;
    logic        wrTake;
    logic        rdTake;
    logic        wrCtrl;
    logic        wrEvent;
    logic        wrKnown;
    logic        rdKnown;
    logic [31:0] rdMux;
    logic [31:0] byteMask;
    logic [2:0]  eventSet;
    logic [2:0]  eventClr;

    assign wrTake   = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
    assign rdTake   = s_axi_arvalid & ~rvalid_reg;
    assign s_axi_awready = wrTake;
    assign s_axi_wready  = wrTake;
    assign s_axi_arready = ~rvalid_reg;
    assign wrCtrl   = wrTake & (s_axi_awaddr == hbpc_pkg::CTRL_OFFSET);
    assign wrEvent  = wrTake & (s_axi_awaddr == hbpc_pkg::EVENT_OFFSET);
    assign wrKnown  = (s_axi_awaddr == hbpc_pkg::CTRL_OFFSET) | (s_axi_awaddr ==
                      hbpc_pkg::STATUS_OFFSET) | (s_axi_awaddr == hbpc_pkg::LATCH_OFFSET)
                      | (s_axi_awaddr == hbpc_pkg::EVENT_OFFSET);
    assign rdKnown  = (s_axi_araddr == hbpc_pkg::CTRL_OFFSET) | (s_axi_araddr ==
                      hbpc_pkg::STATUS_OFFSET) | (s_axi_araddr == hbpc_pkg::LATCH_OFFSET)
                      | (s_axi_araddr == hbpc_pkg::EVENT_OFFSET);
    assign byteMask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign eventSet = {adsRise, hostRead, hostWrite};
    assign eventClr = (wrEvent & s_axi_wstrb[0]) ? s_axi_wdata[2:0] : 3'h0;
    assign rdMux    = (s_axi_araddr == hbpc_pkg::CTRL_OFFSET)   ? ctrl_reg :
                      (s_axi_araddr == hbpc_pkg::STATUS_OFFSET) ?
                          {26'h0, strapDone_reg, powerDown_reg, width_reg, async_reg,
                           eepPresent_reg} :
                      (s_axi_araddr == hbpc_pkg::LATCH_OFFSET)  ?
                          {15'h0, latchQualN_reg, latchAddr_reg, 1'b0} :
                      (s_axi_araddr == hbpc_pkg::EVENT_OFFSET)  ? {29'h0, event_reg} :
                      32'h0;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg   <= hbpc_pkg::CTRL_RESET;
            event_reg  <= hbpc_pkg::EVENT_RESET;
            bvalid_reg <= 1'b0;
            bresp_reg  <= hbpc_pkg::RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg  <= hbpc_pkg::RESP_OKAY;
            rdata_reg  <= '0;
        end else begin
            if (wrCtrl) begin
                ctrl_reg <= (ctrl_reg & ~byteMask) | (s_axi_wdata & byteMask);
            end
            // A hardware event in the clearing cycle survives the clear.
            event_reg <= (event_reg & ~eventClr) | eventSet;
            if (wrTake) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wrKnown ? hbpc_pkg::RESP_OKAY : hbpc_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (rdTake) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rdMux;
                rresp_reg  <= rdKnown ? hbpc_pkg::RESP_OKAY : hbpc_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp  = rresp_reg;
    assign s_axi_rdata  = rdata_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_latch_capture;
        @(posedge mclk) disable iff (!resetn)
        adsRise |=> (latchAddr_reg == $past(pin.addr)) && (latchQualN_reg == $past(pin.qualN));
    endproperty
    a_latch_capture: assert property (p_latch_capture) else $error("latch missed strobe");

    property p_latch_hold;
        @(posedge mclk) disable iff (!resetn)
        !adsRise |=> $stable(latchAddr_reg) && $stable(latchQualN_reg);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed early");

    property p_powerdown;
        @(posedge mclk) disable iff (!resetn)
        !chip_powerdown_n [*4] |-> powerDown;
    endproperty
    a_powerdown: assert property (p_powerdown) else $error("power-down not entered");

    property p_width_strap;
        @(posedge mclk) disable iff (!resetn)
        $rose(strapDone_reg) && !eepPresent_reg && !async_reg |->
            busWidth == ($past(pin.serialIn) ? hbpc_pkg::HBPC_WIDTH16 : hbpc_pkg::HBPC_WIDTH8);
    endproperty
    a_width_strap: assert property (p_width_strap) else $error("bad width strap");

    property p_async_width;
        @(posedge mclk) disable iff (!resetn)
        strapDone_reg && asyncMode |-> busWidth == hbpc_pkg::HBPC_WIDTH32;
    endproperty
    a_async_width: assert property (p_async_width) else $error("async not 32-bit");

    property p_hit_qual;
        @(posedge mclk) disable iff (!resetn)
        hostHit |-> !effQualN;
    endproperty
    a_hit_qual: assert property (p_hit_qual) else $error("hit without qualifier");

    property p_sync_dir;
        @(posedge mclk) disable iff (!resetn)
        !asyncMode && (hostWrite || hostRead) |-> hostWrite == pin.writeNotRead && hostHit;
    endproperty
    a_sync_dir: assert property (p_sync_dir) else $error("sync direction wrong");

    property p_async_write;
        @(posedge mclk) disable iff (!resetn)
        asyncMode && hostWrite |-> $fell(pin.writeN) && hostHit;
    endproperty
    a_async_write: assert property (p_async_write) else $error("write off strobe");

    property p_read_drive;
        @(posedge mclk) disable iff (!resetn)
        readDriveEn |-> asyncMode && !pin.readN && hostHit;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read drive off strobe");

    property p_eep_valid;
        @(posedge mclk) disable iff (!resetn)
        eepromDataValid |=> eepromDataOut == $past(pin.serialIn);
    endproperty
    a_eep_valid: assert property (p_eep_valid) else $error("serial data not passed");

    property p_eep_strap;
        @(posedge mclk) disable iff (!resetn)
        $rose(strapDone_reg) |-> eepromDataValid == $past(pin.eepromStrap);
    endproperty
    a_eep_strap: assert property (p_eep_strap) else $error("memory strap wrong");
endmodule : hbpc_host_pins

// File: hbpc_pkg.sv
// Constants shared by the host bus pin control block.
// Function
// - With the serial memory fitted, its data output feeds the serial-memory input pin.
// - Without serial memory, that input straps width: low 8-bit, high 16-bit, ignored 32-bit.
// - Synchronous accesses: direction pin high means write, low means read.
// - An address is ours only while the active-low qualifier is low; with the address latch enabled the code uses the latched qualifier instead.
// - Asynchronous writes are signalled and accepted on the low write strobe.
// - Address lines and qualifier are captured on the address strobe rising edge.
// - Power-down input low powers the chip down; high or floating runs normally.
// - Memory-enable strap high means serial memory present; low or open means absent.
// - Bus-style strap low selects synchronous bus; high selects 32-bit asynchronous or burst.
// - Asynchronous reads are signalled by the low read strobe; data driven during it.
package hbpc_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET  = 8'h04;
    localparam logic [7:0]  LATCH_OFFSET   = 8'h08;
    localparam logic [7:0]  EVENT_OFFSET   = 8'h0c;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_LATCH_EN_BIT = 0;
    localparam int CTRL_BASE_LSB     = 4;
    localparam int STAT_EEP_BIT      = 0;
    localparam int STAT_ASYNC_BIT    = 1;
    localparam int STAT_WIDTH_LSB    = 2;
    localparam int STAT_CHIP_POWERDOWN_N_BIT    = 4;
    localparam int STAT_DONE_BIT     = 5;
    localparam int LATCH_QUAL_BIT    = 16;
    localparam int EVT_WRITE_BIT     = 0;
    localparam int EVT_READ_BIT      = 1;
    localparam int EVT_LATCH_BIT     = 2;
    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [2:0]  EVENT_RESET    = 3'h0;
    // Idle levels of the synchronised pins, so no false strobe edge follows reset.
    localparam logic [23:0] PIN_IDLE       = 24'h0f_8000;
    localparam logic [1:0]  STRAP_SETTLE   = 2'h3;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        HBPC_WIDTH8  = 2'h0,
        HBPC_WIDTH16 = 2'h1,
        HBPC_WIDTH32 = 2'h2
    } hbpc_width_type;
endpackage : hbpc_pkg

// File: hbpc_pin_if.sv
// Synchronised host pin levels passed from the synchroniser to the control logic.
`timescale 1ns/10ps
interface hbpc_pin_if;
    logic        serialIn;
    logic        eepromStrap;
    logic        busStyle;
    logic        writeNotRead;
    logic        qualN;
    logic        writeN;
    logic        readN;
    logic        latchStrobeN;
    logic        powerdownN;
    logic [15:1] addr;
    modport drv (output serialIn, eepromStrap, busStyle, writeNotRead, qualN, writeN,
                 readN, latchStrobeN, powerdownN, addr);
    modport use_side (input serialIn, eepromStrap, busStyle, writeNotRead, qualN, writeN,
                      readN, latchStrobeN, powerdownN, addr);
endinterface : hbpc_pin_if

// File: hbpc_pin_sync.sv
// Two-stage synchroniser for every host pin of the block.
`timescale 1ns/10ps
module hbpc_pin_sync #(
    parameter int           W       = 24,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] pinsIn,
    output logic      [W-1:0] pinsOut
);
    // The first stage is read only by the second stage.
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            // Resetting to the pins' idle levels avoids a false edge at release.
            stage1_reg <= RST_VAL;
            stage2_reg <= RST_VAL;
        end else begin
            stage1_reg <= pinsIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign pinsOut = stage2_reg;
endmodule : hbpc_pin_sync

// File: hbpc_host_model.sv
// Host processor model that drives the host bus pins of the pin control block.
`timescale 1ns/10ps
module hbpc_host_model (
    input  wire logic   mclk,
    output logic        dirWr,
    output logic        qualN,
    output logic        writeN,
    output logic        readN,
    output logic        latchStrobeN,
    output logic        pdN,
    output logic [15:1] addr
);
    initial begin
        dirWr  = 1'b0;
        qualN  = 1'b1;
        writeN = 1'b1;
        readN  = 1'b1;
        latchStrobeN = 1'b1;
        pdN    = 1'b1;
        addr   = 15'h0000;
    end
    // Qualifier, direction and address settle before any strobe falls.
    task put(input logic q, input logic w, input logic p, input logic [15:1] a);
        @(posedge mclk);
        qualN <= q;
        dirWr <= w;
        pdN   <= p;
        addr  <= a;
        repeat (5) @(posedge mclk);
    endtask : put
    // Levels are held for several cycles because the pins are only sampled on mclk.
    task pulse(input int which, input int len);
        @(posedge mclk);
        if (which == 0) writeN <= 1'b0;
        else if (which == 1) readN <= 1'b0;
        else latchStrobeN <= 1'b0;
        repeat (len) @(posedge mclk);
        writeN <= 1'b1;
        readN  <= 1'b1;
        latchStrobeN <= 1'b1;
        repeat (5) @(posedge mclk);
    endtask : pulse
endmodule : hbpc_host_model

// File: tb_host_bus_pin_control.sv
// Self-checking testbench of the host bus pin control block.
`timescale 1ns/10ps
module tb_host_bus_pin_control;
    logic        mclk = 1'b0, resetn = 1'b0, presentStrap = 1'b0, styleStrap = 1'b0;
    logic        serialIn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, serial;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        dirWr, qualN, writeN, readN, latchStrobeN, pdN, eepromDataOut, eepromDataValid;
    logic        powerDown, asyncMode, hostHit, hostWrite, hostRead, readDriveEn;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  busWidth, bresp, rresp;
    logic [31:0] rdata;
    logic [15:1] addr, hitAddr;
    logic [11:0] base;
    logic [33:0] busNotes[$];
    logic [1:0]  pinNotes[$];
    int          fails = 0;
    int          cmp_count = 0;

    always #50 mclk = ~mclk;

    hbpc_host_model i_hbpc_host_model (.mclk(mclk), .dirWr(dirWr), .qualN(qualN),
        .writeN(writeN), .readN(readN), .latchStrobeN(latchStrobeN), .pdN(pdN), .addr(addr));

    hbpc_host_pins i_hbpc_host_pins (.mclk(mclk), .resetn(resetn), .eeprom_serial_in(serialIn),
        .eeprom_present_strap(presentStrap), .bus_style_strap(styleStrap),
        .sync_write_not_read(dirWr), .address_qualifier_n(qualN), .write_strobe_n(writeN),
        .read_strobe_n(readN), .address_latch_strobe_n(latchStrobeN), .chip_powerdown_n(pdN),
        .host_address_lines(addr), .eepromDataOut(eepromDataOut),
        .eepromDataValid(eepromDataValid), .powerDown(powerDown), .busWidth(busWidth),
        .asyncMode(asyncMode), .hostHit(hostHit), .hostWrite(hostWrite), .hostRead(hostRead),
        .readDriveEn(readDriveEn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    task check(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task final_report;
        if (pinNotes.size() != 0 || busNotes.size() != 0) fails++;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    function automatic logic [31:0] stat(input logic p, input logic s, input logic e,
                                         input logic pd);
        logic [1:0] w;
        // The bus-style strap wins: a 32-bit bus ignores the other straps.
        w = s ? 2'(hbpc_pkg::HBPC_WIDTH32) : (p ? 2'(hbpc_pkg::HBPC_WIDTH16) :
            (e ? 2'(hbpc_pkg::HBPC_WIDTH16) : 2'(hbpc_pkg::HBPC_WIDTH8)));
        return {26'h0, 1'b1, pd, w, s, p};
    endfunction : stat

    // A pulse that nobody announced is compared against zero and so fails.
    always @(posedge mclk) begin
        if (resetn === 1'b1 && (hostWrite === 1'b1 || hostRead === 1'b1))
            check({hostRead, hostWrite}, pinNotes.size() ? pinNotes.pop_front() : 2'h0);
        if (rvalid === 1'b1 && rready === 1'b1) check({rresp, rdata}, busNotes.pop_front());
        if (bvalid === 1'b1 && bready === 1'b1) check({bresp, 32'h0}, busNotes.pop_front());
    end

    // ------------------------------------------------------------------
    // Bus and reset tasks
    // ------------------------------------------------------------------
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        busNotes.push_back({r, 32'h0});
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : axi_wr

    task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        busNotes.push_back({r, d});
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : axi_rd

    task do_reset(input logic p, input logic s, input logic e);
        @(posedge mclk);
        resetn       <= 1'b0;
        presentStrap <= p;
        styleStrap   <= s;
        serialIn     <= e;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        repeat (12) @(posedge mclk);
    endtask : do_reset

    initial begin
        repeat (8000) @(posedge mclk);
        fails++;
        final_report();
    end

    initial begin
        void'($urandom(32'hd51bfd38));
        for (int i = 0; i < 8; i++) begin
            do_reset(i[2], i[1], i[0]);
            axi_rd(hbpc_pkg::STATUS_OFFSET, stat(i[2], i[1], i[0], 1'b0), 2'h0);
            check(eepromDataValid, i[2]);
            check({busWidth, asyncMode}, 3'(stat(i[2], i[1], i[0], 1'b0) >> 1));
            check(eepromDataOut, i[2] & i[0]);
        end
        axi_rd(hbpc_pkg::CTRL_OFFSET, hbpc_pkg::CTRL_RESET, 2'h0);
        axi_rd(hbpc_pkg::LATCH_OFFSET, 32'h0001_0000, 2'h0);
        serial = 1'($urandom);
        do_reset(1'b0, 1'b1, serial);
        base    = 12'($urandom);
        hitAddr = {base, 3'($urandom)};
        axi_wr(hbpc_pkg::CTRL_OFFSET, {16'h0, base, 4'h0}, 2'h0);
        axi_rd(hbpc_pkg::CTRL_OFFSET, {16'h0, base, 4'h0}, 2'h0);
        axi_rd(8'h10, 32'h0, 2'h2);
        axi_wr(8'h14, 32'hffff_ffff, 2'h2);
        i_hbpc_host_model.put(1'b0, 1'b0, 1'b1, {~base, 3'h0});
        check(hostHit, 1'b0);
        i_hbpc_host_model.put(1'b0, 1'b0, 1'b1, hitAddr);
        check(hostHit, 1'b1);
        pinNotes.push_back(2'b01);
        i_hbpc_host_model.pulse(0, 3);
        i_hbpc_host_model.put(1'b1, 1'b0, 1'b1, hitAddr);
        check(hostHit, 1'b0);
        i_hbpc_host_model.pulse(0, 3);
        i_hbpc_host_model.put(1'b0, 1'b0, 1'b1, hitAddr);
        pinNotes.push_back(2'b10);
        fork
            i_hbpc_host_model.pulse(1, 6);
            begin
                repeat (5) @(posedge mclk);
                check(readDriveEn, 1'b1);
            end
        join
        axi_rd(hbpc_pkg::EVENT_OFFSET, 32'h3, 2'h0);
        axi_wr(hbpc_pkg::EVENT_OFFSET, 32'h7, 2'h0);
        axi_rd(hbpc_pkg::EVENT_OFFSET, 32'h0, 2'h0);
        axi_wr(hbpc_pkg::CTRL_OFFSET, {16'h0, base, 4'h1}, 2'h0);
        i_hbpc_host_model.pulse(2, 3);
        i_hbpc_host_model.put(1'b1, 1'b0, 1'b1, ~hitAddr);
        axi_rd(hbpc_pkg::LATCH_OFFSET, {15'h0, 1'b0, hitAddr, 1'b0}, 2'h0);
        pinNotes.push_back(2'b01);
        i_hbpc_host_model.pulse(0, 3);
        axi_rd(hbpc_pkg::EVENT_OFFSET, 32'h5, 2'h0);
        i_hbpc_host_model.put(1'b1, 1'b0, 1'b0, ~hitAddr);
        check(powerDown, 1'b1);
        axi_rd(hbpc_pkg::STATUS_OFFSET, stat(1'b0, 1'b1, serial, 1'b1), 2'h0);
        i_hbpc_host_model.pulse(0, 3);
        i_hbpc_host_model.put(1'b1, 1'b0, 1'b1, ~hitAddr);
        check(powerDown, 1'b0);
        do_reset(1'b0, 1'b0, 1'b1);
        axi_wr(hbpc_pkg::CTRL_OFFSET, {16'h0, base, 4'h0}, 2'h0);
        pinNotes.push_back(2'b01);
        i_hbpc_host_model.put(1'b0, 1'b1, 1'b1, hitAddr);
        i_hbpc_host_model.put(1'b1, 1'b0, 1'b1, hitAddr);
        pinNotes.push_back(2'b10);
        i_hbpc_host_model.put(1'b0, 1'b0, 1'b1, hitAddr);
        i_hbpc_host_model.put(1'b1, 1'b0, 1'b1, hitAddr);
        final_report();
    end
endmodule : tb_host_bus_pin_control
